// File: inc/acs_pkg.sv
package acs_pkg;

	// Register byte offsets
	localparam logic [7:0] ACS_CTRL0_OFF = 8'h00;
	localparam logic [7:0] ACS_BUFSTAT_OFF = 8'h04;
	localparam logic [7:0] ACS_TIMING_OFF = 8'h08;
	localparam logic [7:0] ACS_TRIG_OFF = 8'h0C;
	localparam logic [7:0] ACS_CHSEL_OFF = 8'h10;
	localparam logic [7:0] ACS_IRQ_OFF = 8'h14;
	localparam logic [7:0] ACS_RESULT_OFF = 8'h18;

	// Control register zero fields
	localparam int ACS_POWER_BIT = 0;
	localparam int ACS_GO_BIT = 1;
	localparam int ACS_MODE_LSB = 2;
	localparam int ACS_MULTI_BIT = 4;
	localparam int ACS_CONT_BIT = 5;

	// Buffer status fields
	localparam int ACS_RDPTR_LSB = 0;
	localparam int ACS_OVF_BIT = 2;
	localparam int ACS_EMPTY_BIT = 3;

	// Timing register fields
	localparam int ACS_RATE_LSB = 0;
	localparam int ACS_ACQ_LSB = 4;
	localparam int ACS_DIV_LSB = 8;

	localparam int ACS_FLAG_BIT = 0;

	// Sequence modes
	localparam logic [1:0] ACS_SEQ_ONE = 2'h0;
	localparam logic [1:0] ACS_SEQ_TWO = 2'h1;
	localparam logic [1:0] ACS_SIM_ONE = 2'h2;
	localparam logic [1:0] ACS_SIM_TWO = 2'h3;

	// Timing in converter clock periods
	localparam logic [3:0] ACS_CONV_TADS = 4'hC;
	localparam logic [3:0] ACS_ACQ_MIN_TADS = 4'h2;

	localparam logic [1:0] ACS_RESP_OKAY = 2'h0;
	localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		ACS_IDLE = 2'h0,
		ACS_ACQ = 2'h1,
		ACS_CONV = 2'h3
	} acs_state_t;

endpackage

// File: rtl/acs_sequencer.sv
// Operation
// (R01) Single mode converts one chosen group channel
// (R02) Single-shot sets flag after conversion ends
// (R03) Continuous loop flags per interrupt rate field
// (R04) Sequential one: group A then B
// (R05) Sequential two: groups A, B, C, D
// (R06) Simultaneous one: sample A,B together, convert both
// (R07) Simultaneous two adds C,D pair afterwards
// (R08) Writing go bit starts the sequence
// (R09) Five trigger enables; any enabled source starts
// (R10) Trigger sets go; completion clears it
// (R11) Software waits power-up settling before starting
// (R12) Acquisition lasts at least two periods
// (R13) Programmed acquisition time precedes each conversion
// (R14) Software polls go, flag or empty
// (R15) Conversion takes exactly twelve periods
// (R16) Sequential modes want acquisition of twelve
// (R17) Software sets enables, clears flag first
// (R18) Software reads results, clears flag, reconfigures
// (R19) Four-entry buffer; empty low when unread
// (R20) Overwriting unread entry sets overflow flag
// (R21) Read pointer names next entry returned
// (R22) Results fill consecutive entries in order
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module acs_sequencer
	import acs_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Trigger sources
	input wire logic external_trigger_pin,
	input wire logic trig_timer_five,
	input wire logic trig_input_capture_one,
	input wire logic trig_compare_module_two,
	input wire logic trig_pwm_rise,
	// Converter core
	output logic adc_sample_a,
	output logic adc_sample_b,
	output logic [3:0] adc_chan_a,
	output logic [3:0] adc_chan_b,
	output logic adc_convert,
	output logic adc_convert_sel,
	input wire logic [9:0] adc_result
);

	typedef struct packed {
		acs_state_t state;
		logic [1:0] slot;
		logic holder;
		logic [7:0] tad_cnt;
		logic [3:0] ph;
		logic power;
		logic go;
		logic cont;
		logic multi;
		logic [1:0] seq_mode;
		logic [1:0] irq_rate;
		logic [3:0] acq_time;
		logic [7:0] tad_div;
		logic [4:0] trig_en;
		logic [7:0] chsel;
		logic irq_flag;
		logic ovf;
		logic [3:0] buf_valid;
		logic [3:0][9:0] buf_mem;
		logic [1:0] wr_ptr;
		logic [1:0] rd_ptr;
		logic [1:0] rate_cnt;
		logic [2:0] ext_sync;
		logic ext_level;
		logic have_aw;
		logic [7:0] aw_addr;
		logic have_w;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic sample_a;
		logic sample_b;
		logic [3:0] chan_a;
		logic [3:0] chan_b;
		logic convert;
		logic conv_sel;
	} acs_regs_t;

	acs_regs_t r_reg;
	acs_regs_t r_next;

	function automatic logic [31:0] acs_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
		begin
			if (st[i])
				m[8*i +: 8] = wd[8*i +: 8];
		end
		return m;
	endfunction

	function automatic logic [3:0] acs_chan(input logic [1:0] grp, input logic [7:0] sel);
		return {grp, sel[2*grp +: 2]};
	endfunction

	// Group converted in a slot: single mode takes the mode field
	function automatic logic [1:0] acs_group(input logic multi, input logic [1:0] mode, input logic [1:0] slot);
		return multi ? slot : mode;
	endfunction

	logic [4:0] trig_pulse;
	logic tad_tick;
	logic [3:0] acq_len;
	logic [1:0] last_slot;
	logic simul;
	logic conv_done;
	logic seq_end;
	logic pop;
	logic [31:0] ctrl0_img;
	logic [31:0] timing_img;
	logic [31:0] wimg;

	always_comb
	begin
		r_next = r_reg;
		wimg = 32'h0;
		pop = 1'b0;
		// Middle flop alone feeds the third; change counts when they agree
		r_next.ext_sync = {r_reg.ext_sync[1:0], external_trigger_pin};
		if (r_reg.ext_sync[1] == r_reg.ext_sync[2])
			r_next.ext_level = r_reg.ext_sync[2];
		trig_pulse = {trig_pwm_rise, trig_compare_module_two, trig_input_capture_one, trig_timer_five,
			r_next.ext_level & ~r_reg.ext_level};
		tad_tick = (r_reg.tad_cnt == r_reg.tad_div);
		acq_len = (r_reg.acq_time < ACS_ACQ_MIN_TADS) ? ACS_ACQ_MIN_TADS : r_reg.acq_time; // R12 R13
		simul = r_reg.multi & r_reg.seq_mode[1];
		case ({r_reg.multi, r_reg.seq_mode})
			{1'b1, ACS_SEQ_ONE}: last_slot = 2'h1; // R04
			{1'b1, ACS_SEQ_TWO}: last_slot = 2'h3; // R05
			{1'b1, ACS_SIM_ONE}: last_slot = 2'h1; // R06
			{1'b1, ACS_SIM_TWO}: last_slot = 2'h3; // R07
			default: last_slot = 2'h0; // R01
		endcase
		conv_done = (r_reg.state == ACS_CONV) && tad_tick && (r_reg.ph == ACS_CONV_TADS - 4'h1); // R15
		seq_end = conv_done && (r_reg.slot == last_slot);

		// Read side of the bus; a result read pops the buffer
		if (r_reg.rvalid && s_axi_rready)
		begin
			r_next.rvalid = 1'b0;
			r_next.arready = 1'b1;
		end
		ctrl0_img = 32'h0;
		ctrl0_img[ACS_POWER_BIT] = r_reg.power;
		ctrl0_img[ACS_GO_BIT] = r_reg.go;
		ctrl0_img[ACS_MODE_LSB +: 2] = r_reg.seq_mode;
		ctrl0_img[ACS_MULTI_BIT] = r_reg.multi;
		ctrl0_img[ACS_CONT_BIT] = r_reg.cont;
		timing_img = 32'h0;
		timing_img[ACS_RATE_LSB +: 2] = r_reg.irq_rate;
		timing_img[ACS_ACQ_LSB +: 4] = r_reg.acq_time;
		timing_img[ACS_DIV_LSB +: 8] = r_reg.tad_div;
		if (s_axi_arvalid && r_reg.arready)
		begin
			r_next.arready = 1'b0;
			r_next.rvalid = 1'b1;
			r_next.rresp = ACS_RESP_OKAY;
			r_next.rdata = 32'h0;
			case (s_axi_araddr)
				ACS_CTRL0_OFF: r_next.rdata = ctrl0_img;
				ACS_BUFSTAT_OFF:
				begin
					r_next.rdata[ACS_RDPTR_LSB +: 2] = r_reg.rd_ptr; // R21
					r_next.rdata[ACS_OVF_BIT] = r_reg.ovf;
					r_next.rdata[ACS_EMPTY_BIT] = ~|r_reg.buf_valid; // R19
				end
				ACS_TIMING_OFF: r_next.rdata = timing_img;
				ACS_TRIG_OFF: r_next.rdata[4:0] = r_reg.trig_en;
				ACS_CHSEL_OFF: r_next.rdata[7:0] = r_reg.chsel;
				ACS_IRQ_OFF: r_next.rdata[ACS_FLAG_BIT] = r_reg.irq_flag;
				ACS_RESULT_OFF:
				begin
					r_next.rdata[9:0] = r_reg.buf_mem[r_reg.rd_ptr];
					pop = r_reg.buf_valid[r_reg.rd_ptr];
				end
				default: r_next.rresp = ACS_RESP_SLVERR;
			endcase
		end
		if (pop)
		begin
			r_next.buf_valid[r_reg.rd_ptr] = 1'b0;
			r_next.rd_ptr = r_reg.rd_ptr + 2'h1; // R21
		end

		// Sequencer; hardware clears go before software and triggers act
		r_next.tad_cnt = tad_tick ? 8'h0 : r_reg.tad_cnt + 8'h1;
		case (r_reg.state)
			ACS_IDLE:
			begin
				if (r_reg.go && r_reg.power)
				begin
					r_next.state = ACS_ACQ; // R08 R13
					r_next.slot = 2'h0;
					r_next.ph = 4'h0;
					r_next.tad_cnt = 8'h0;
					r_next.rate_cnt = 2'h0;
					r_next.holder = 1'b0;
				end
			end
			ACS_ACQ:
			begin
				if (tad_tick)
					r_next.ph = r_reg.ph + 4'h1;
				if (tad_tick && (r_reg.ph == acq_len - 4'h1))
				begin
					r_next.state = ACS_CONV; // R13
					r_next.ph = 4'h0;
					r_next.holder = 1'b0;
				end
			end
			ACS_CONV:
			begin
				if (tad_tick)
					r_next.ph = r_reg.ph + 4'h1;
				if (conv_done)
				begin
					r_next.ph = 4'h0;
					r_next.slot = r_reg.slot + 2'h1;
					// Second holder of a pair converts without a new acquisition
					if (simul && !r_reg.slot[0])
					begin
						r_next.holder = 1'b1; // R06 R07
					end
					else
					begin
						// Release the hold so the next pair tracks its own channels
						r_next.holder = 1'b0;
						r_next.state = ACS_ACQ; // R04 R05 R07
					end
					if (seq_end)
					begin
						r_next.slot = 2'h0;
						if (r_reg.cont)
							r_next.state = ACS_ACQ;
						else
						begin
							r_next.state = ACS_IDLE;
							r_next.go = 1'b0; // R10
							r_next.irq_flag = 1'b1; // R02
						end
					end
				end
			end
			default: r_next.state = ACS_IDLE;
		endcase
		// Continuous loop flags every (rate+1) results rather than every one
		if (conv_done && r_reg.cont)
		begin
			r_next.rate_cnt = r_reg.rate_cnt + 2'h1;
			if (r_reg.rate_cnt == r_reg.irq_rate)
			begin
				r_next.irq_flag = 1'b1; // R03
				r_next.rate_cnt = 2'h0;
			end
		end
		if (conv_done)
		begin
			r_next.buf_mem[r_reg.wr_ptr] = adc_result;
			r_next.buf_valid[r_reg.wr_ptr] = 1'b1; // R19
			r_next.wr_ptr = r_reg.wr_ptr + 2'h1; // R22
		end

		// Write side of the bus
		if (s_axi_awvalid && r_reg.awready)
		begin
			r_next.have_aw = 1'b1;
			r_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r_reg.wready)
		begin
			r_next.have_w = 1'b1;
			r_next.wdata = s_axi_wdata;
			r_next.wstrb = s_axi_wstrb;
		end
		if (r_reg.bvalid && s_axi_bready)
			r_next.bvalid = 1'b0;
		if (r_reg.have_aw && r_reg.have_w && !r_reg.bvalid)
		begin
			r_next.have_aw = 1'b0;
			r_next.have_w = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = ACS_RESP_OKAY;
			case (r_reg.aw_addr)
				ACS_CTRL0_OFF:
				begin
					wimg = acs_merge(ctrl0_img, r_reg.wdata, r_reg.wstrb);
					r_next.power = wimg[ACS_POWER_BIT];
					r_next.go = wimg[ACS_GO_BIT] & wimg[ACS_POWER_BIT]; // R08
					r_next.seq_mode = wimg[ACS_MODE_LSB +: 2];
					r_next.multi = wimg[ACS_MULTI_BIT];
					r_next.cont = wimg[ACS_CONT_BIT];
					if (!r_next.go)
						r_next.state = ACS_IDLE;
				end
				ACS_BUFSTAT_OFF:
				begin
					if (r_reg.wstrb[0] && r_reg.wdata[ACS_OVF_BIT])
						r_next.ovf = 1'b0;
				end
				ACS_TIMING_OFF:
				begin
					wimg = acs_merge(timing_img, r_reg.wdata, r_reg.wstrb);
					r_next.irq_rate = wimg[ACS_RATE_LSB +: 2];
					r_next.acq_time = wimg[ACS_ACQ_LSB +: 4];
					r_next.tad_div = wimg[ACS_DIV_LSB +: 8];
				end
				ACS_TRIG_OFF:
				begin
					if (r_reg.wstrb[0])
						r_next.trig_en = r_reg.wdata[4:0]; // R09
				end
				ACS_CHSEL_OFF:
				begin
					if (r_reg.wstrb[0])
						r_next.chsel = r_reg.wdata[7:0];
				end
				ACS_IRQ_OFF:
				begin
					if (r_reg.wstrb[0] && r_reg.wdata[ACS_FLAG_BIT])
						r_next.irq_flag = 1'b0;
				end
				ACS_RESULT_OFF: ;
				default: r_next.bresp = ACS_RESP_SLVERR;
			endcase
		end
		// Hardware sets win over clears in the same cycle
		if (conv_done && r_reg.buf_valid[r_reg.wr_ptr] && !(pop && r_reg.rd_ptr == r_reg.wr_ptr))
			r_next.ovf = 1'b1; // R20
		if (conv_done && r_reg.cont && r_reg.rate_cnt == r_reg.irq_rate)
			r_next.irq_flag = 1'b1; // R03
		if (seq_end && !r_reg.cont)
			r_next.irq_flag = 1'b1; // R02
		if (|(trig_pulse & r_reg.trig_en) && r_reg.power && r_reg.state == ACS_IDLE)
			r_next.go = 1'b1; // R09 R10
		r_next.awready = !r_next.have_aw && !r_next.bvalid;
		r_next.wready = !r_next.have_w && !r_next.bvalid;

		// Core drive, registered from the next state
		r_next.sample_a = (r_next.state == ACS_ACQ); // R12
		r_next.sample_b = (r_next.state == ACS_ACQ) && r_next.multi && r_next.seq_mode[1]; // R06
		r_next.convert = (r_next.state == ACS_CONV);
		r_next.conv_sel = r_next.holder;
		r_next.chan_a = acs_chan(acs_group(r_next.multi, r_next.seq_mode, r_next.slot), r_next.chsel); // R01
		r_next.chan_b = acs_chan(r_next.slot + 2'h1, r_next.chsel);
		if (r_next.holder)
			r_next.chan_a = r_reg.chan_a;
		if (r_next.holder)
			r_next.chan_b = r_reg.chan_b;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r_reg <= '0;
			r_reg.state <= ACS_IDLE;
			r_reg.awready <= 1'b1;
			r_reg.wready <= 1'b1;
			r_reg.arready <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	assign s_axi_awready = r_reg.awready;
	assign s_axi_wready = r_reg.wready;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_arready = r_reg.arready;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rdata = r_reg.rdata;
	assign s_axi_rresp = r_reg.rresp;
	assign adc_sample_a = r_reg.sample_a;
	assign adc_sample_b = r_reg.sample_b;
	assign adc_chan_a = r_reg.chan_a;
	assign adc_chan_b = r_reg.chan_b;
	assign adc_convert = r_reg.convert;
	assign adc_convert_sel = r_reg.conv_sel;

	// Helper counters for the checks below
	logic [11:0] conv_cyc;
	logic [11:0] samp_cyc;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			conv_cyc <= 12'h0;
			samp_cyc <= 12'h0;
		end
		else
		begin
			// Restart at each result; a pair keeps convert high throughout
			conv_cyc <= (adc_convert && !conv_done) ? conv_cyc + 12'h1 : 12'h0;
			samp_cyc <= adc_sample_a ? samp_cyc + 12'h1 : 12'h0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_conv_twelve_tads: assert property (conv_done |-> conv_cyc ==
		12'(ACS_CONV_TADS) * (12'(r_reg.tad_div) + 12'h1) - 12'h1) else $error("conversion length wrong"); // R15
	a_acq_min_len: assert property ($fell(adc_sample_a) && adc_convert |-> samp_cyc >=
		12'(ACS_ACQ_MIN_TADS) * (12'(r_reg.tad_div) + 12'h1)) else $error("acquisition too short"); // R12
	a_empty_after_wr: assert property (conv_done |=> r_reg.buf_valid != 4'h0) else $error("buffer still empty"); // R19
	a_ovf_on_overwrite: assert property (conv_done && r_reg.buf_valid[r_reg.wr_ptr] && !pop |=> r_reg.ovf)
		else $error("overflow not flagged"); // R20
	a_trig_sets_go: assert property (|(trig_pulse & r_reg.trig_en) && r_reg.power && r_reg.state == ACS_IDLE
		|=> r_reg.go) else $error("trigger did not set go"); // R10
	a_single_done: assert property (seq_end && !r_reg.cont && !(r_reg.have_aw && r_reg.have_w && !r_reg.bvalid)
		|=> !r_reg.go && r_reg.irq_flag && r_reg.state == ACS_IDLE) else $error("single shot end wrong"); // R02
	a_wr_ptr_order: assert property (conv_done |=> r_reg.wr_ptr == $past(r_reg.wr_ptr) + 2'h1)
		else $error("results out of order"); // R22
	a_simul_sample: assert property (adc_sample_a && r_reg.multi && r_reg.seq_mode[1] |-> adc_sample_b)
		else $error("holders not sampling together"); // R06
	a_single_group: assert property (adc_convert && !r_reg.multi |-> adc_chan_a[3:2] == r_reg.seq_mode)
		else $error("single channel group wrong"); // R01
	a_seq_two_next: assert property (conv_done && r_reg.multi && r_reg.seq_mode == ACS_SEQ_TWO
		&& r_reg.slot != 2'h3 && r_reg.go |=> adc_sample_a && adc_chan_a[3:2] == $past(r_reg.slot) + 2'h1)
		else $error("sequence group order wrong"); // R05

endmodule

// File: verification/acs_core_model.sv
`timescale 1ns/1ps
module acs_core_model
(
	// Clock
	aclk,
	// Holder and conversion controls
	adc_sample_a,
	adc_sample_b,
	adc_chan_a,
	adc_chan_b,
	adc_convert,
	adc_convert_sel,
	// Conversion result
	adc_result
);
	input wire logic aclk;
	input wire logic adc_sample_a;
	input wire logic adc_sample_b;
	input wire logic [3:0] adc_chan_a;
	input wire logic [3:0] adc_chan_b;
	input wire logic adc_convert;
	input wire logic adc_convert_sel;
	output logic [9:0] adc_result;

	logic [3:0] held_a = 4'h0;
	logic [3:0] held_b = 4'h0;
	logic [9:0] idle_pat = 10'h155;

	// Holders track their channel while sampling, freeze after
	always @(posedge aclk)
	begin
		if (adc_sample_a)
			held_a <= adc_chan_a;
		if (adc_sample_b)
			held_b <= adc_chan_b;
		idle_pat <= ~idle_pat;
	end

	// Outside a conversion the bus wanders, so a late sample is caught
	assign adc_result = adc_convert ? {3'b101, adc_convert_sel, 2'b00, adc_convert_sel ? held_b : held_a} : idle_pat;
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb
	import acs_pkg::*;
;
	typedef struct {logic [7:0] ctrl; int n; logic [9:0] res [4];} acs_row_t;

	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic [4:0] trig_v = 5'h00;
	logic adc_sample_a, adc_sample_b, adc_convert, adc_convert_sel;
	logic [3:0] adc_chan_a, adc_chan_b;
	logic [9:0] adc_result;
	logic [1:0] resp;
	logic c_prev = 1'b0;
	logic sel_prev = 1'b0;
	int err_total = 0;
	int compares = 0;
	int s_cnt = 0;
	int s_len = 0;
	int c_cnt = 0;
	int c_len = 0;
	int n_conv = 0;

	// Results follow the core pattern for channels A=1, B=2, C=3, D=0
	acs_row_t rows [8] = '{
		'{8'h03, 1, '{10'h281, 10'h000, 10'h000, 10'h000}},
		'{8'h07, 1, '{10'h286, 10'h000, 10'h000, 10'h000}},
		'{8'h0B, 1, '{10'h28B, 10'h000, 10'h000, 10'h000}},
		'{8'h0F, 1, '{10'h28C, 10'h000, 10'h000, 10'h000}},
		'{8'h13, 2, '{10'h281, 10'h286, 10'h000, 10'h000}},
		'{8'h17, 4, '{10'h281, 10'h286, 10'h28B, 10'h28C}},
		'{8'h1B, 2, '{10'h281, 10'h2C6, 10'h000, 10'h000}},
		'{8'h1F, 4, '{10'h281, 10'h2C6, 10'h28B, 10'h2CC}}};

	acs_sequencer acs_sequencer_i
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.external_trigger_pin(trig_v[0]), .trig_timer_five(trig_v[1]),
		.trig_input_capture_one(trig_v[2]), .trig_compare_module_two(trig_v[3]),
		.trig_pwm_rise(trig_v[4]), .adc_sample_a, .adc_sample_b, .adc_chan_a,
		.adc_chan_b, .adc_convert, .adc_convert_sel, .adc_result
	);

	acs_core_model acs_core_model_i
	(
		.aclk, .adc_sample_a, .adc_sample_b, .adc_chan_a, .adc_chan_b,
		.adc_convert, .adc_convert_sel, .adc_result
	);

	always #5 aclk = ~aclk;

	// Phase lengths in aclk cycles; a select change splits a pair
	always @(posedge aclk)
	begin
		s_cnt <= adc_sample_a ? s_cnt + 1 : 0;
		if (!adc_sample_a && s_cnt != 0)
			s_len <= s_cnt;
		c_cnt <= !adc_convert ? 0 : (c_prev && adc_convert_sel == sel_prev) ? c_cnt + 1 : 1;
		if (c_prev && (!adc_convert || adc_convert_sel != sel_prev))
		begin
			c_len <= c_cnt;
			n_conv <= n_conv + 1;
		end
		c_prev <= adc_convert;
		sel_prev <= adc_convert_sel;
	end

	task wrap_up;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			t++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1 && t < 64);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (t >= 64)
			err_total++;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		int t;
		t = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			t++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1 && t < 64);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (t >= 64)
			err_total++;
	endtask

	task wait_idle;
		logic [31:0] d;
		int n;
		n = 0;
		do
		begin
			repeat (8) @(posedge aclk);
			rd(ACS_CTRL0_OFF, d);
			n++;
		end
		while (d[ACS_GO_BIT] !== 1'b0 && n < 100);
		chk("go cleared", d[ACS_GO_BIT], 0);
	endtask

	// Pin input is asynchronous and needs several cycles to pass sync
	task pulse(input int i);
		@(posedge aclk);
		trig_v <= 5'h01 << i;
		repeat (i == 0 ? 4 : 1) @(posedge aclk);
		trig_v <= 5'h00;
		repeat (3) @(posedge aclk);
	endtask

	initial
	begin
		repeat (40000) @(posedge aclk);
		err_total++;
		wrap_up();
	end

	initial
	begin
		logic [31:0] d;
		int rp;
		int k;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ACS_CTRL0_OFF, d);
		chk("ctrl0 reset", d, 32'h0);
		rd(ACS_BUFSTAT_OFF, d);
		chk("bufstat reset", d, 32'h1 << ACS_EMPTY_BIT);
		rd(ACS_IRQ_OFF, d);
		chk("flag reset", d, 32'h0);
		rd(8'h1C, d);
		chk("unmapped read resp", resp, ACS_RESP_SLVERR);
		wr(8'h20, 32'hFFFFFFFF);
		chk("unmapped write resp", resp, ACS_RESP_SLVERR);
		$display("test reset done");
		wr(ACS_IRQ_OFF, 32'h1);
		wr(ACS_CHSEL_OFF, 32'h39);
		wr(ACS_TIMING_OFF, 32'h1C0);
		wr(ACS_CTRL0_OFF, 32'h1);
		repeat (1000) @(posedge aclk);
		rp = 0;
		foreach (rows[i])
		begin
			wr(ACS_CTRL0_OFF, {24'h0, rows[i].ctrl});
			wait_idle();
			rd(ACS_IRQ_OFF, d);
			chk("flag at end", d, 32'h1);
			chk("acq length", s_len, 24);
			chk("conv length", c_len, 24);
			for (int j = 0; j < rows[i].n; j++)
			begin
				rd(ACS_RESULT_OFF, d);
				chk("result", d, {22'h0, rows[i].res[j]});
			end
			rp = (rp + rows[i].n) % 4;
			rd(ACS_BUFSTAT_OFF, d);
			chk("bufstat drained", d, (32'h1 << ACS_EMPTY_BIT) | rp);
			wr(ACS_IRQ_OFF, 32'h1);
			rd(ACS_IRQ_OFF, d);
			chk("flag cleared", d, 32'h0);
			$display("test row %0d done", i);
		end
		wr(ACS_TIMING_OFF, 32'h0);
		wr(ACS_CTRL0_OFF, 32'h1);
		for (int i = 0; i < 5; i++)
		begin
			wr(ACS_TRIG_OFF, ~(32'h1 << i) & 32'h1F);
			pulse(i);
			rd(ACS_CTRL0_OFF, d);
			chk("go refused", d[ACS_GO_BIT], 0);
			wr(ACS_TRIG_OFF, 32'h1 << i);
			pulse(i);
			rd(ACS_CTRL0_OFF, d);
			chk("go by trigger", d[ACS_GO_BIT], 1);
			wait_idle();
			chk("acq minimum", s_len, 2);
			chk("conv length", c_len, 12);
			rd(ACS_RESULT_OFF, d);
			chk("trigger result", d, 32'h281);
			rd(ACS_IRQ_OFF, d);
			chk("trigger flag", d, 32'h1);
			wr(ACS_IRQ_OFF, 32'h1);
		end
		wr(ACS_TRIG_OFF, 32'h0);
		$display("test triggers done");
		wr(ACS_TIMING_OFF, 32'h1C0);
		wr(ACS_CTRL0_OFF, 32'h17);
		wait_idle();
		wr(ACS_CTRL0_OFF, 32'h03);
		wait_idle();
		rd(ACS_BUFSTAT_OFF, d);
		chk("overflow set", d[ACS_OVF_BIT], 1);
		wr(ACS_BUFSTAT_OFF, 32'h1 << ACS_OVF_BIT);
		rd(ACS_BUFSTAT_OFF, d);
		chk("overflow cleared", d[ACS_OVF_BIT], 0);
		repeat (4) rd(ACS_RESULT_OFF, d);
		rd(ACS_BUFSTAT_OFF, d);
		chk("empty after drain", d[ACS_EMPTY_BIT], 1);
		$display("test overflow done");
		wr(ACS_IRQ_OFF, 32'h1);
		wr(ACS_TIMING_OFF, 32'h1);
		k = n_conv;
		wr(ACS_CTRL0_OFF, 32'h23);
		rp = 0;
		do
		begin
			rd(ACS_IRQ_OFF, d);
			rp++;
		end
		while (d[ACS_FLAG_BIT] !== 1'b1 && rp < 200);
		chk("conversions per flag", n_conv - k, 2);
		wr(ACS_CTRL0_OFF, 32'h1);
		wait_idle();
		$display("test continuous done");
		wr(ACS_CTRL0_OFF, 32'h17);
		repeat (20) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ACS_CTRL0_OFF, d);
		chk("ctrl0 after reset", d, 32'h0);
		rd(ACS_BUFSTAT_OFF, d);
		chk("bufstat after reset", d, 32'h1 << ACS_EMPTY_BIT);
		chk("core idle after reset", {adc_sample_a, adc_convert}, 2'b00);
		$display("test mid-run reset done");
		wrap_up();
	end
endmodule
